// >>> rtl/uart_tx_pkg.sv
package uart_tx_pkg;

    // clock rates in MHz; the two baud sources are synthesised from mclk
    localparam int MCLK_MHZ  = 100;
    localparam int SRC24_MHZ = 24;
    localparam int SRC16_MHZ = 16;

    localparam logic [6:0] SRC_MOD   = 7'(MCLK_MHZ);
    localparam logic [6:0] SRC24_INC = 7'(SRC24_MHZ);
    localparam logic [6:0] SRC16_INC = 7'(SRC16_MHZ);

    // generator ticks per serial bit, and stop lengths in ticks
    localparam int         OVERSAMPLE   = 16;
    localparam logic [5:0] BIT_TICKS    = 6'(OVERSAMPLE);
    localparam logic [5:0] STOP15_TICKS = 6'(OVERSAMPLE * 3 / 2);
    localparam logic [5:0] STOP2_TICKS  = 6'(OVERSAMPLE * 2);
    localparam logic [2:0] WLEN_BASE    = 3'h5;

    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;

    // register byte addresses
    localparam logic [5:0] ADDR_TX_DATA   = 6'h00;
    localparam logic [5:0] ADDR_LINE_CTRL = 6'h04;
    localparam logic [5:0] ADDR_FIFO_CTRL = 6'h08;
    localparam logic [5:0] ADDR_DIVISOR   = 6'h0c;
    localparam logic [5:0] ADDR_CLK_SEL   = 6'h10;
    localparam logic [5:0] ADDR_LINE_STAT = 6'h14;
    localparam logic [5:0] ADDR_INT_STAT  = 6'h18;
    localparam logic [5:0] ADDR_INT_MASK  = 6'h1c;
    localparam logic [5:0] ADDR_INT_ID    = 6'h20;

    // field positions
    localparam int FIFO_EN_BIT    = 0;
    localparam int FIFO_FLUSH_BIT = 1;
    localparam int CLK_SEL_BIT    = 0;
    localparam int INT_THR_EMPTY  = 0;
    localparam int INT_TX_DONE    = 1;
    localparam int INT_W          = 2;

    // reset values
    localparam logic [5:0]  LINE_CTRL_RST = 6'h03;
    localparam logic [15:0] DIVISOR_RST   = 16'h0001;

    // interrupt identification codes, highest priority first
    localparam logic [3:0] INT_ID_NONE      = 4'h1;
    localparam logic [3:0] INT_ID_THR_EMPTY = 4'h2;
    localparam logic [3:0] INT_ID_TX_DONE   = 4'h4;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic       stick;
        logic       even;
        logic       par_en;
        logic       stop_long;
        logic [1:0] wlen;
    } line_ctrl_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP
    } tx_state_t;

endpackage

// >>> rtl/uart_transmit_path.sv
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// Function
// - baud generator runs from a selectable 24 MHz or 16 MHz source
// - 24 MHz source covers standard rates from 50 Hz to 115.2 kHz
// - 16 MHz source covers rates from 125 kHz to 1000 kHz
// - one start bit, then five to eight data bits
// - stop length of one, one and a half or two bits
// - parity even, odd, sticky or none
// - generator divides its source by a 16-bit divisor, 1 to 65535
// - writing a character to holding register or FIFO starts transmission
// - pending character loaded into shifter with start, parity and stop bits
// - order: start, data LSB first, parity, stop
// - each serial bit lasts sixteen generator ticks
// - holding-empty interrupt when holding register or FIFO becomes empty
// - FIFO operation only while FIFO control bit 0 is set
// - transmit FIFO holds up to sixteen bytes
// - with FIFO, characters go back to back until it is empty
// - interrupt causes are prioritised, highest reported first
// - generator can produce the MIDI serial rate
module uart_transmit_path (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [5:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [5:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             txd_o,
    output logic             irq_o
);

    // ---------------- bus slave ----------------
    uart_tx_pkg::wr_req_t wr_reg;
    logic                 aw_held_reg;
    logic                 w_held_reg;
    logic                 awready_reg;
    logic                 wready_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic                 arready_reg;
    logic                 rvalid_reg;
    logic [31:0]          rdata_reg;
    logic [1:0]           rresp_reg;

    wire aw_take  = s_axi_awvalid_i & awready_reg;
    wire w_take   = s_axi_wvalid_i & wready_reg;
    wire aw_held  = aw_held_reg | aw_take;
    wire w_held   = w_held_reg | w_take;
    // a write commits once both halves are in and the last response is gone
    wire wr_fire  = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire b_done   = bvalid_reg & s_axi_bready_i;
    wire ar_take  = s_axi_arvalid_i & arready_reg;
    wire r_done   = rvalid_reg & s_axi_rready_i;
    wire [5:0] wa = wr_reg.addr;
    wire wr_lane0 = wr_fire & wr_reg.strb[0];

    wire wr_tx    = wr_lane0 & (wa == uart_tx_pkg::ADDR_TX_DATA);
    wire wr_line  = wr_lane0 & (wa == uart_tx_pkg::ADDR_LINE_CTRL);
    wire wr_fifo  = wr_lane0 & (wa == uart_tx_pkg::ADDR_FIFO_CTRL);
    wire wr_div   = wr_fire & (wa == uart_tx_pkg::ADDR_DIVISOR);
    wire wr_csel  = wr_lane0 & (wa == uart_tx_pkg::ADDR_CLK_SEL);
    wire wr_istat = wr_lane0 & (wa == uart_tx_pkg::ADDR_INT_STAT);
    wire wr_imask = wr_lane0 & (wa == uart_tx_pkg::ADDR_INT_MASK);
    wire wr_known = (wa == uart_tx_pkg::ADDR_TX_DATA) | (wa == uart_tx_pkg::ADDR_LINE_CTRL) |
                    (wa == uart_tx_pkg::ADDR_FIFO_CTRL) | (wa == uart_tx_pkg::ADDR_DIVISOR) |
                    (wa == uart_tx_pkg::ADDR_CLK_SEL) | (wa == uart_tx_pkg::ADDR_LINE_STAT) |
                    (wa == uart_tx_pkg::ADDR_INT_STAT) | (wa == uart_tx_pkg::ADDR_INT_MASK) |
                    (wa == uart_tx_pkg::ADDR_INT_ID);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_reg      <= '0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= uart_tx_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                wr_reg.addr <= s_axi_awaddr_i;
            end
            if (w_take) begin
                wr_reg.data <= s_axi_wdata_i;
                wr_reg.strb <= s_axi_wstrb_i;
            end
            aw_held_reg <= aw_held & ~wr_fire;
            w_held_reg  <= w_held & ~wr_fire;
            awready_reg <= ~(aw_held & ~wr_fire);
            wready_reg  <= ~(w_held & ~wr_fire);
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_known ? uart_tx_pkg::RESP_OKAY : uart_tx_pkg::RESP_SLVERR;
            end else if (b_done) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ---------------- control registers ----------------
    uart_tx_pkg::line_ctrl_t line_ctrl_reg;
    logic                    fifo_en_reg;
    logic [15:0]             divisor_reg;
    logic                    clk_sel_reg;
    logic [uart_tx_pkg::INT_W-1:0] int_stat_reg;
    logic [uart_tx_pkg::INT_W-1:0] int_mask_reg;

    // toggling the enable or writing the flush bit empties the queue
    wire fifo_flush = wr_fifo & (wr_reg.data[uart_tx_pkg::FIFO_FLUSH_BIT] |
                      (wr_reg.data[uart_tx_pkg::FIFO_EN_BIT] != fifo_en_reg));

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            line_ctrl_reg <= uart_tx_pkg::LINE_CTRL_RST;
            fifo_en_reg   <= 1'b0;
            divisor_reg   <= uart_tx_pkg::DIVISOR_RST;
            clk_sel_reg   <= 1'b0;
            int_mask_reg  <= '0;
        end else begin
            if (wr_line) begin
                line_ctrl_reg <= wr_reg.data[5:0];
            end
            if (wr_fifo) begin
                fifo_en_reg <= wr_reg.data[uart_tx_pkg::FIFO_EN_BIT];
            end
            if (wr_div) begin
                if (wr_reg.strb[0]) divisor_reg[7:0] <= wr_reg.data[7:0];
                if (wr_reg.strb[1]) divisor_reg[15:8] <= wr_reg.data[15:8];
            end
            if (wr_csel) begin
                clk_sel_reg <= wr_reg.data[uart_tx_pkg::CLK_SEL_BIT];
            end
            if (wr_imask) begin
                int_mask_reg <= wr_reg.data[uart_tx_pkg::INT_W-1:0];
            end
        end
    end

    // ---------------- baud generator ----------------
    // fractional accumulator makes the 24/16 MHz source rate from mclk;
    // jitter is one mclk period, well inside one sixteenth of a bit
    logic [6:0]  src_acc_reg;
    logic        src_tick_reg;
    logic [15:0] div_cnt_reg;
    logic        baud_tick_reg;

    wire [6:0] src_inc = clk_sel_reg ? uart_tx_pkg::SRC16_INC : uart_tx_pkg::SRC24_INC;
    wire [6:0] src_sum = src_acc_reg + src_inc;
    wire       src_wrap = src_sum >= uart_tx_pkg::SRC_MOD;
    // divisor 0 behaves as 1; 24 MHz / 48 / 16 gives the MIDI rate
    wire [15:0] div_top = (divisor_reg == 16'h0000) ? 16'h0000 : divisor_reg - 16'h0001;
    wire        div_end = div_cnt_reg >= div_top;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            src_acc_reg   <= '0;
            src_tick_reg  <= 1'b0;
            div_cnt_reg   <= '0;
            baud_tick_reg <= 1'b0;
        end else begin
            src_acc_reg   <= src_wrap ? src_sum - uart_tx_pkg::SRC_MOD : src_sum;
            src_tick_reg  <= src_wrap;
            baud_tick_reg <= src_tick_reg & div_end;
            if (src_tick_reg) begin
                div_cnt_reg <= div_end ? 16'h0000 : div_cnt_reg + 16'h0001;
            end
        end
    end

    // ---------------- holding register / FIFO ----------------
    logic [7:0]                   fifo_mem [uart_tx_pkg::FIFO_DEPTH];
    logic [uart_tx_pkg::FIFO_AW-1:0] wr_ptr_reg;
    logic [uart_tx_pkg::FIFO_AW-1:0] rd_ptr_reg;
    logic [uart_tx_pkg::FIFO_AW:0]   count_reg;

    // with the FIFO off only one entry is usable: the holding register
    wire fifo_full  = fifo_en_reg ? (count_reg == 5'(uart_tx_pkg::FIFO_DEPTH))
                                  : (count_reg != 5'h00);
    wire fifo_empty = count_reg == 5'h00;
    wire push       = wr_tx & ~fifo_full & ~fifo_flush;
    logic pop;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            fifo_mem[wr_ptr_reg] <= wr_reg.data[7:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || fifo_flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 4'h1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 4'h1;
            count_reg <= count_reg + {4'h0, push} - {4'h0, pop};
        end
    end

    // ---------------- shifter ----------------
    uart_tx_pkg::tx_state_t state_reg;
    logic [7:0]             shift_reg;
    logic [2:0]             bit_cnt_reg;
    logic [5:0]             tick_cnt_reg;
    logic                   parity_reg;
    logic                   txd_reg;

    wire [2:0] last_bit = 3'(line_ctrl_reg.wlen) + uart_tx_pkg::WLEN_BASE - 3'h1;
    // 1.5 stop bits only with five-bit words, as on the classic part
    wire [5:0] stop_ticks = !line_ctrl_reg.stop_long ? uart_tx_pkg::BIT_TICKS :
                            (line_ctrl_reg.wlen == 2'b00) ? uart_tx_pkg::STOP15_TICKS :
                            uart_tx_pkg::STOP2_TICKS;
    wire [5:0] phase_ticks = (state_reg == uart_tx_pkg::TX_STOP) ? stop_ticks : uart_tx_pkg::BIT_TICKS;
    wire       phase_end   = baud_tick_reg & (tick_cnt_reg == phase_ticks - 6'h01);
    wire [7:0] head        = fifo_mem[rd_ptr_reg];
    wire [7:0] data_mask   = 8'hff >> (3'h7 - last_bit);
    wire       data_xor    = ^(head & data_mask);
    // sticky parity sends the inverse of the even-select bit
    wire       par_bit     = line_ctrl_reg.stick ? ~line_ctrl_reg.even :
                             (line_ctrl_reg.even ? data_xor : ~data_xor);
    wire       load        = ~fifo_empty & ~fifo_flush &
                             ((state_reg == uart_tx_pkg::TX_IDLE) |
                              ((state_reg == uart_tx_pkg::TX_STOP) & phase_end));
    wire       frame_done  = (state_reg == uart_tx_pkg::TX_STOP) & phase_end & ~load;
    assign pop = load;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg    <= uart_tx_pkg::TX_IDLE;
            shift_reg    <= '0;
            bit_cnt_reg  <= '0;
            tick_cnt_reg <= '0;
            parity_reg   <= 1'b0;
            txd_reg      <= 1'b1;
        end else begin
            if (baud_tick_reg) begin
                tick_cnt_reg <= phase_end ? 6'h00 : tick_cnt_reg + 6'h01;
            end
            if (load) begin
                state_reg    <= uart_tx_pkg::TX_START;
                shift_reg    <= head;
                parity_reg   <= par_bit;
                bit_cnt_reg  <= '0;
                tick_cnt_reg <= '0;
                txd_reg      <= 1'b0;
            end else if (phase_end) begin
                unique case (state_reg)
                    uart_tx_pkg::TX_IDLE: begin
                        txd_reg <= 1'b1;
                    end
                    uart_tx_pkg::TX_START: begin
                        state_reg <= uart_tx_pkg::TX_DATA;
                        txd_reg   <= shift_reg[0];
                        shift_reg <= shift_reg >> 1;
                    end
                    uart_tx_pkg::TX_DATA: begin
                        if (bit_cnt_reg == last_bit) begin
                            state_reg <= line_ctrl_reg.par_en ? uart_tx_pkg::TX_PARITY : uart_tx_pkg::TX_STOP;
                            txd_reg   <= line_ctrl_reg.par_en ? parity_reg : 1'b1;
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            txd_reg     <= shift_reg[0];
                            shift_reg   <= shift_reg >> 1;
                        end
                    end
                    uart_tx_pkg::TX_PARITY: begin
                        state_reg <= uart_tx_pkg::TX_STOP;
                        txd_reg   <= 1'b1;
                    end
                    uart_tx_pkg::TX_STOP: begin
                        state_reg <= uart_tx_pkg::TX_IDLE;
                        txd_reg   <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ---------------- interrupts ----------------
    logic empty_d_reg;
    logic irq_reg;

    wire [uart_tx_pkg::INT_W-1:0] int_set;
    assign int_set[uart_tx_pkg::INT_THR_EMPTY] = fifo_empty & ~empty_d_reg;
    assign int_set[uart_tx_pkg::INT_TX_DONE]   = frame_done;
    wire [uart_tx_pkg::INT_W-1:0] int_clr     = wr_istat ? wr_reg.data[uart_tx_pkg::INT_W-1:0] : '0;
    wire [uart_tx_pkg::INT_W-1:0] int_pending = int_stat_reg & int_mask_reg;
    wire [3:0] int_id = int_pending[uart_tx_pkg::INT_THR_EMPTY] ? uart_tx_pkg::INT_ID_THR_EMPTY :
                        int_pending[uart_tx_pkg::INT_TX_DONE]   ? uart_tx_pkg::INT_ID_TX_DONE :
                        uart_tx_pkg::INT_ID_NONE;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            empty_d_reg  <= 1'b1;
            int_stat_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            empty_d_reg  <= fifo_empty;
            // a new event wins over a clear in the same cycle
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
            irq_reg      <= |(((int_stat_reg & ~int_clr) | int_set) & int_mask_reg);
        end
    end

    // ---------------- read path ----------------
    wire [5:0] ra = s_axi_araddr_i;
    wire [31:0] line_stat = {26'h0, count_reg, 1'b0} |
                            {31'h0, fifo_empty & (state_reg == uart_tx_pkg::TX_IDLE)} |
                            {24'h0, ~fifo_full, 7'h00};
    logic [31:0] rd_mux;
    logic        rd_ok;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        unique case (ra)
            uart_tx_pkg::ADDR_TX_DATA:   rd_mux = 32'h0000_0000;
            uart_tx_pkg::ADDR_LINE_CTRL: rd_mux = {26'h0, line_ctrl_reg};
            uart_tx_pkg::ADDR_FIFO_CTRL: rd_mux = {31'h0, fifo_en_reg};
            uart_tx_pkg::ADDR_DIVISOR:   rd_mux = {16'h0, divisor_reg};
            uart_tx_pkg::ADDR_CLK_SEL:   rd_mux = {31'h0, clk_sel_reg};
            uart_tx_pkg::ADDR_LINE_STAT: rd_mux = line_stat;
            uart_tx_pkg::ADDR_INT_STAT:  rd_mux = {30'h0, int_stat_reg};
            uart_tx_pkg::ADDR_INT_MASK:  rd_mux = {30'h0, int_mask_reg};
            uart_tx_pkg::ADDR_INT_ID:    rd_mux = {28'h0, int_id};
            default:                     rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= uart_tx_pkg::RESP_OKAY;
        end else begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= rd_ok ? uart_tx_pkg::RESP_OKAY : uart_tx_pkg::RESP_SLVERR;
            end else if (r_done) begin
                rvalid_reg <= 1'b0;
            end
            arready_reg <= ~(ar_take | (rvalid_reg & ~r_done));
        end
    end

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o  = wready_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign txd_o           = txd_reg;
    assign irq_o           = irq_reg;

endmodule

// >>> verification/uart_transmit_path_checker.sv
`timescale 1ns/100ps
module uart_transmit_path_checker (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic [5:0]  s_axi_awaddr_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0]  s_axi_wstrb_i,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        txd_o,
    input wire logic        irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence mask_cleared;
        wr_taken ##0 (s_axi_awaddr_i == uart_tx_pkg::ADDR_INT_MASK && s_axi_wstrb_i[0] && s_axi_wdata_i[1:0] == 2'h0);
    endsequence
    chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_o)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data late");
    chk_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address taken while data pending");
    chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped before ready");
    chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped before ready");
    chk_start_width: assert property ($fell(txd_o) |-> !txd_o [*8])
        else $error("start bit too short");
    chk_mark_width: assert property ($rose(txd_o) |-> txd_o [*8])
        else $error("high bit too short");
    chk_irq_masked: assert property (mask_cleared |-> ##[1:4] !irq_o)
        else $error("interrupt stays up after masking");
endmodule
bind uart_transmit_path uart_transmit_path_checker u_checker (.*);

// >>> verification/uart_line_monitor.sv
`timescale 1ns/100ps
module uart_line_monitor (
    input  wire logic        txd_i,
    input  wire logic [15:0] bit_ns_i,
    input  wire logic [3:0]  nbits_i,
    output logic [11:0]      frame_o,
    output logic             valid_o
);
    // remote end set to the same rate and format, samples each bit mid-way
    initial begin
        valid_o = 1'h0;
        frame_o = 12'h000;
        forever begin
            @(negedge txd_i);
            #(bit_ns_i / 2);
            frame_o = 12'h000;
            for (int i = 0; i < nbits_i; i++) begin
                frame_o[i] = txd_i;
                if (i < nbits_i - 1) #(bit_ns_i);
            end
            valid_o = 1'h1;
            #1;
            valid_o = 1'h0;
        end
    end
endmodule

// >>> verification/uart_transmit_path_test.sv
`timescale 1ns/100ps
module uart_transmit_path_test;
    logic        mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, txd, irq, fvalid;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, nbits;
    logic [1:0]  bresp, rresp;
    logic [15:0] bit_ns;
    logic [11:0] fword;
    logic [34:0] e;
    int          errors, samples_checked;
    logic [34:0] rq[$];
    logic [1:0]  bq[$];
    logic [11:0] fq[$];
    uart_tx_pkg::line_ctrl_t lc;
    localparam logic [1:0] OKAY = uart_tx_pkg::RESP_OKAY;

    uart_transmit_path u_uart_transmit_path (.mclk_i(mclk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .txd_o(txd), .irq_o(irq));
    uart_line_monitor u_uart_line_monitor (.txd_i(txd), .bit_ns_i(bit_ns), .nbits_i(nbits),
        .frame_o(fword), .valid_o(fvalid));

    always #5 mclk = ~mclk;

    task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cmp_frame(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: frame %h, wanted %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] frame_of(input uart_tx_pkg::line_ctrl_t c, input logic [7:0] d);
        logic [7:0]  m;
        logic [11:0] f;
        logic        p;
        m = 8'hff >> (3 - c.wlen);
        p = c.stick ? ~c.even : ^(d & m) ^ ~c.even;
        f = 12'(d & m) << 1;
        f |= 12'(c.par_en ? {2'h3, p} : 3'h7) << (6 + c.wlen);
        return f & ~(12'hfff << (7 + c.wlen + c.par_en));
    endfunction
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge mclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r, input logic care);
        rq.push_back({care, r, d});
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
    endtask
    task automatic set_line(input uart_tx_pkg::line_ctrl_t c);
        wr(uart_tx_pkg::ADDR_LINE_CTRL, {26'h0, c}, OKAY);
        nbits <= 4'(7 + c.wlen + c.par_en);
    endtask
    task automatic send(input logic [7:0] d);
        fq.push_back(frame_of(lc, d));
        wr(uart_tx_pkg::ADDR_TX_DATA, {24'h0, d}, OKAY);
    endtask
    task automatic drain;
        while (fq.size() > 0) @(posedge mclk);
        repeat (bit_ns / 5) @(posedge mclk);
    endtask
    task automatic summarize;
        if (rq.size() > 0 || bq.size() > 0 || fq.size() > 0) errors++;
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        if (bvalid && bready) cmp_word({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (rvalid && rready) begin
            e = rq.pop_front();
            cmp_word({rresp, e[34] ? rdata : e[31:0]}, e[33:0]);
        end
    end
    always @(posedge fvalid) cmp_frame(fword, fq.size() > 0 ? fq.pop_front() : 12'hfff);

    initial begin
        #950000;
        errors++;
        summarize();
    end

    initial begin
        {mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {errors, samples_checked} = '0;
        wstrb = 4'hf;
        bit_ns = 16'h03e8;
        nbits = 4'h9;
        lc = uart_tx_pkg::LINE_CTRL_RST;
        void'($urandom(4));
        repeat (8) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        cmp_word({33'h0, txd}, 34'h1);
        cmp_word({33'h0, irq}, 34'h0);
        rd(uart_tx_pkg::ADDR_LINE_CTRL, 32'h3, OKAY, 1'h1);
        rd(uart_tx_pkg::ADDR_DIVISOR, 32'h1, OKAY, 1'h1);
        rd(uart_tx_pkg::ADDR_INT_ID, 32'h1, OKAY, 1'h1);
        rd(uart_tx_pkg::ADDR_LINE_STAT, 32'h81, OKAY, 1'h1);
        rd(6'h24, 32'h0, uart_tx_pkg::RESP_SLVERR, 1'h0);
        wr(6'h3c, 32'h5a, uart_tx_pkg::RESP_SLVERR);
        wr(uart_tx_pkg::ADDR_CLK_SEL, 32'h1, OKAY);
        for (int i = 0; i < 16; i++) begin
            lc = '{stick: i[1] & i[0], even: i[1] ^ (i[3] & i[0]), par_en: |i[1:0], stop_long: i[2], wlen: 2'(i >> 2)};
            set_line(lc);
            send(8'($urandom));
            drain();
        end
        lc = uart_tx_pkg::LINE_CTRL_RST;
        set_line(lc);
        wr(uart_tx_pkg::ADDR_CLK_SEL, 32'h0, OKAY);
        bit_ns <= 16'h029b;
        send(8'($urandom));
        drain();
        wr(uart_tx_pkg::ADDR_DIVISOR, 32'h30, OKAY);
        bit_ns <= 16'h7d00;
        send(8'($urandom));
        drain();
        wr(uart_tx_pkg::ADDR_DIVISOR, 32'h1, OKAY);
        wr(uart_tx_pkg::ADDR_CLK_SEL, 32'h1, OKAY);
        bit_ns <= 16'h03e8;
        wr(uart_tx_pkg::ADDR_INT_STAT, 32'h3, OKAY);
        wr(uart_tx_pkg::ADDR_INT_MASK, 32'h3, OKAY);
        wr(uart_tx_pkg::ADDR_FIFO_CTRL, 32'h1, OKAY);
        for (int i = 0; i < 16; i++) send(8'($urandom));
        drain();
        while (irq !== 1'h1) @(posedge mclk);
        cmp_word({33'h0, irq}, 34'h1);
        rd(uart_tx_pkg::ADDR_INT_STAT, 32'h3, OKAY, 1'h1);
        rd(uart_tx_pkg::ADDR_INT_ID, 32'h2, OKAY, 1'h1);
        wr(uart_tx_pkg::ADDR_INT_STAT, 32'h1, OKAY);
        rd(uart_tx_pkg::ADDR_INT_ID, 32'h4, OKAY, 1'h1);
        wr(uart_tx_pkg::ADDR_INT_MASK, 32'h0, OKAY);
        @(posedge mclk);
        cmp_word({33'h0, irq}, 34'h0);
        send(8'($urandom));
        repeat (2) wr(uart_tx_pkg::ADDR_TX_DATA, 32'h55, OKAY);
        wr(uart_tx_pkg::ADDR_FIFO_CTRL, 32'h3, OKAY);
        rd(uart_tx_pkg::ADDR_LINE_STAT, 32'h80, OKAY, 1'h1);
        drain();
        wr(uart_tx_pkg::ADDR_FIFO_CTRL, 32'h0, OKAY);
        send(8'($urandom));
        send(8'($urandom));
        wr(uart_tx_pkg::ADDR_TX_DATA, 32'h33, OKAY);
        drain();
        // a third frame here means a full holding register took a byte
        repeat (1200) @(posedge mclk);
        summarize();
    end
endmodule
